// >>> logic/regbank_pkg.sv
package regbank_pkg;

  localparam int REG_W = 8;
  localparam int ADDR_W = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 3'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 3'h1;
  localparam logic [ADDR_W-1:0] CMD_OFS = 3'h2;
  localparam logic [ADDR_W-1:0] DBGCTRL_OFS = 3'h3;
  localparam logic [ADDR_W-1:0] OUT_OFS = 3'h4;
  localparam logic [ADDR_W-1:0] SET_ALIAS_REGISTER_OFS = 3'h5;
  localparam logic [ADDR_W-1:0] CLEAR_ALIAS_REGISTER_OFS = 3'h6;
  localparam logic [ADDR_W-1:0] TOGGLE_ALIAS_REGISTER_OFS = 3'h7;

  // Implemented bits; all others are reserved
  localparam logic [REG_W-1:0] CTRL_MASK = 8'h3F;
  localparam logic [REG_W-1:0] STATUS_MASK = 8'h0F;
  localparam logic [REG_W-1:0] CMD_MASK = 8'h03;
  localparam logic [REG_W-1:0] DBGCTRL_MASK = 8'h01;
  localparam logic [REG_W-1:0] OUT_MASK = 8'hFF;

  // Command field positions
  localparam int CMD_SRST_BIT = 0;
  localparam int CMD_STROBE_BIT = 1;

  // Reset values
  localparam logic [REG_W-1:0] CTRL_RST = 8'h05;
  localparam logic [REG_W-1:0] DBGCTRL_RST = 8'h00;
  localparam logic [REG_W-1:0] OUT_RST = 8'h00;

endpackage

// >>> logic/alias_pair.sv
`timescale 1ns/100ps
module alias_pair #(
  parameter int                  W     = 8,
  parameter logic [W-1:0]        RST_V = '0
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  input  wire logic         srst_i,
  input  wire logic         we_base_i,
  input  wire logic         we_set_i,
  input  wire logic         we_clear_i,
  input  wire logic         we_toggle_i,
  input  wire logic [W-1:0] wdata_i,
  output logic      [W-1:0] q_o
);

  if (W < 1) begin : g_chk
    $error("alias_pair: W must be at least 1");
  end

  for (genvar i = 0; i < W; i++) begin : g_bit
    logic bit_d;
    // Zero bits in an alias write keep the stored bit
    assign bit_d = we_base_i                 ? wdata_i[i] :
                   (we_set_i && wdata_i[i])  ? 1'b1 :
                   (we_clear_i && wdata_i[i]) ? 1'b0 :
                   (we_toggle_i && wdata_i[i]) ? ~q_o[i] : q_o[i];
    always_ff @(posedge mclk_i) begin
      if (!rst_n_i || srst_i) begin
        q_o[i] <= RST_V[i];
      end else begin
        q_o[i] <= bit_d;
      end
    end
  end

endmodule

// >>> logic/regbank.sv
`timescale 1ns/100ps
module regbank #(
  parameter int DATA_W = regbank_pkg::REG_W
) (
  input  wire logic                             mclk_i,
  input  wire logic                             rst_n_i,
  input  wire logic [regbank_pkg::ADDR_W-1:0]   addr_i,
  input  wire logic                             wr_i,
  input  wire logic                             rd_i,
  input  wire logic [DATA_W-1:0]                wdata_i,
  input  wire logic [DATA_W-1:0]                status_i,
  output logic      [DATA_W-1:0]                rdata_o,
  output logic      [DATA_W-1:0]                ctrl_o,
  output logic      [DATA_W-1:0]                dbg_o,
  output logic      [DATA_W-1:0]                pair_o,
  output logic                                  strobe_o
);
  import regbank_pkg::*;

  if (DATA_W != REG_W) begin : g_chk
    $error("regbank: DATA_W must equal REG_W");
  end

  // Offsets 4 to 7 are told apart from the rest by address bit 2 alone
  if (ADDR_W != 3) begin : g_chk_addr
    $error("regbank: ADDR_W must be 3 for this register map");
  end

  logic [DATA_W-1:0] ctrl_q;
  logic [DATA_W-1:0] ctrl_d;
  logic [DATA_W-1:0] dbg_q;
  logic [DATA_W-1:0] dbg_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              strobe_q;
  logic [DATA_W-1:0] pair_w;

  // Address decode
  wire we_ctrl   = wr_i && (addr_i == CTRL_OFS);
  wire we_cmd    = wr_i && (addr_i == CMD_OFS);
  wire we_dbg    = wr_i && (addr_i == DBGCTRL_OFS);
  wire we_base   = wr_i && (addr_i == OUT_OFS);
  wire we_set    = wr_i && (addr_i == SET_ALIAS_REGISTER_OFS);
  wire we_clear  = wr_i && (addr_i == CLEAR_ALIAS_REGISTER_OFS);
  wire we_toggle = wr_i && (addr_i == TOGGLE_ALIAS_REGISTER_OFS);

  // Peripheral soft reset acts at the edge of the command write itself
  wire srst     = we_cmd && wdata_i[CMD_SRST_BIT];
  wire strobe_d = we_cmd && wdata_i[CMD_STROBE_BIT];

  // Masking on store keeps reserved bits zero even if software misbehaves
  assign ctrl_d = we_ctrl ? (wdata_i & CTRL_MASK) : ctrl_q;
  assign dbg_d  = we_dbg ? (wdata_i & DBGCTRL_MASK) : dbg_q;

  alias_pair #(
    .W     (DATA_W),
    .RST_V (OUT_RST)
  ) u_pair (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .srst_i    (srst),
    .we_base_i (we_base),
    .we_set_i  (we_set),
    .we_clear_i  (we_clear),
    .we_toggle_i (we_toggle),
    .wdata_i   (wdata_i),
    .q_o       (pair_w)
  );

  // Read selection; the command register has no storage and reads as zero
  wire is_pair = addr_i[2];
  assign rdata_d = !rd_i               ? rdata_q :
                   is_pair             ? (pair_w & OUT_MASK) :
                   (addr_i == CTRL_OFS)    ? ctrl_q :
                   (addr_i == STATUS_OFS)  ? (status_i & STATUS_MASK) :
                   (addr_i == DBGCTRL_OFS) ? dbg_q : '0;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || srst) begin
      ctrl_q <= CTRL_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // Debug control survives the peripheral soft reset
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      dbg_q <= DBGCTRL_RST;
    end else begin
      dbg_q <= dbg_d;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_q  <= '0;
      strobe_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      strobe_q <= strobe_d;
    end
  end

  // Pair output is re-registered so every output leaves a flip-flop
  logic [DATA_W-1:0] pair_q;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pair_q <= OUT_RST;
    end else begin
      pair_q <= pair_w;
    end
  end

  assign rdata_o  = rdata_q;
  assign ctrl_o   = ctrl_q;
  assign dbg_o    = dbg_q;
  assign pair_o   = pair_q;
  assign strobe_o = strobe_q;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_rw_store: assert property (
    we_ctrl |=> ctrl_q == ($past(wdata_i) & CTRL_MASK))
    else $error("CTRL did not take the written value");

  a_ro_read: assert property (
    rd_i && addr_i == STATUS_OFS |=> rdata_o == ($past(status_i) & STATUS_MASK))
    else $error("STATUS read does not show live value");

  a_rsv_zero: assert property (
    rd_i && addr_i == CTRL_OFS |=> (rdata_o & ~CTRL_MASK) == '0)
    else $error("Reserved CTRL bits read nonzero");

  a_softrst_vals: assert property (
    srst |=> ctrl_q == CTRL_RST && pair_w == OUT_RST && dbg_q == $past(dbg_d))
    else $error("Soft reset values wrong");

  a_set_bit: assert property (
    we_set |=> pair_w == ($past(pair_w) | $past(wdata_i)))
    else $error("Set alias failed");

  a_clear_bit: assert property (
    we_clear |=> pair_w == ($past(pair_w) & ~$past(wdata_i)))
    else $error("Clear alias failed");

  a_toggle_bit: assert property (
    we_toggle |=> pair_w == ($past(pair_w) ^ $past(wdata_i)))
    else $error("Toggle alias failed");

  a_alias_read: assert property (
    rd_i && is_pair |=> rdata_o == $past(pair_w))
    else $error("Alias read differs from base");

  a_pair_hold: assert property (
    !(we_base || we_set || we_clear || we_toggle || srst) |=> $stable(pair_w))
    else $error("Pair changed without a write");

  a_alias_zero: assert property (
    (we_set || we_clear || we_toggle) && wdata_i == '0 |=> $stable(pair_w))
    else $error("Zero alias write changed the pair");

  a_base_write: assert property (
    we_base |=> pair_w == $past(wdata_i))
    else $error("Base register did not take the written value");

  a_ctrl_hold: assert property (
    !we_ctrl && !srst |=> $stable(ctrl_q))
    else $error("CTRL changed without a write");

  a_rdata_hold: assert property (
    !rd_i |=> $stable(rdata_o))
    else $error("Read data changed without a read");

  a_ro_ignored: assert property (
    wr_i && addr_i == STATUS_OFS |=> $stable(ctrl_q) && $stable(dbg_q) && $stable(pair_w))
    else $error("STATUS write changed a register");

  a_strobe_pulse: assert property (
    we_cmd && wdata_i[CMD_STROBE_BIT] |=> strobe_o)
    else $error("Command strobe missing");

  a_strobe_idle: assert property (
    !(we_cmd && wdata_i[CMD_STROBE_BIT]) |=> !strobe_o)
    else $error("Command strobe without a command");

  a_wo_write: assert property (
    we_cmd && !wdata_i[CMD_SRST_BIT] |=> $stable(ctrl_q) && $stable(dbg_q) && $stable(pair_w))
    else $error("Command write changed a register");

  a_rsv_store: assert property (
    (ctrl_q & ~CTRL_MASK) == '0 && (dbg_q & ~DBGCTRL_MASK) == '0)
    else $error("Reserved bits stored nonzero");

  // Every check here is off while reset is low; this one looks at the release
  a_hard_reset: assert property (
    $rose(rst_n_i) |-> ctrl_q == CTRL_RST && dbg_q == DBGCTRL_RST && pair_w == OUT_RST
      && pair_o == OUT_RST && rdata_o == '0 && !strobe_o)
    else $error("Registers not at reset values after reset");

  a_dbg_hold: assert property (
    !we_dbg |=> $stable(dbg_q))
    else $error("Debug control changed without a write");

  a_read_same: assert property (
    rd_i && is_pair |=> rdata_o == pair_o)
    else $error("Alias read differs from pair output");

  c_set_then_clear: cover property (we_set ##1 we_clear);
  c_toggle_twice: cover property (we_toggle ##1 we_toggle);
  c_soft_reset: cover property (srst);
  c_alias_read: cover property (rd_i && addr_i == TOGGLE_ALIAS_REGISTER_OFS);
  c_rsv_write: cover property (we_ctrl && (wdata_i & ~CTRL_MASK) != '0);

endmodule

// >>> verification/regbank_tb.sv
`timescale 1ns/100ps
module regbank_tb;
  import regbank_pkg::*;
  typedef struct packed {
    logic [2:0] wa;
    logic [7:0] wd;
    logic [2:0] ra;
    logic [7:0] ex;
  } row_s;
  logic              mclk_i   = 1'b0;
  logic              rst_n_i  = 1'b0;
  logic              wr_i     = 1'b0;
  logic              rd_i     = 1'b0;
  logic [ADDR_W-1:0] addr_i   = 3'h0;
  logic [7:0]        wdata_i  = 8'h00;
  logic [7:0]        status_i = 8'h5A;
  logic [7:0]        rdata_o, ctrl_o, dbg_o, pair_o;
  logic              strobe_o;
  int                n_mismatch = 0;
  int                tests_run = 0;
  int                cyc = 0;
  // Rows 0 to 2 set reserved bits on purpose to show they still read zero
  // Rows build on each other: OUT walks A5, AF, 8E, 71
  row_s              rows [8] = '{
    '{3'h0, 8'hFF, 3'h0, 8'h3F},
    '{3'h3, 8'hFF, 3'h3, 8'h01},
    '{3'h1, 8'hFF, 3'h1, 8'h0A},
    '{3'h4, 8'hA5, 3'h4, 8'hA5},
    '{3'h5, 8'h0A, 3'h5, 8'hAF},
    '{3'h6, 8'h21, 3'h6, 8'h8E},
    '{3'h7, 8'hFF, 3'h7, 8'h71},
    '{3'h7, 8'h00, 3'h4, 8'h71}};

  regbank dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wr_i(wr_i),
    .rd_i(rd_i), .wdata_i(wdata_i), .status_i(status_i), .rdata_o(rdata_o),
    .ctrl_o(ctrl_o), .dbg_o(dbg_o), .pair_o(pair_o), .strobe_o(strobe_o));

  always #12.5 mclk_i = ~mclk_i;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Generous ceiling; the sequence needs well under 100 cycles
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One cycle per call; signals never assigned twice in one time step
  task automatic acc(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
    wr_i = w;
    rd_i = r;
    addr_i = a;
    wdata_i = d;
    @(posedge mclk_i);
    #2;
  endtask

  initial begin
    repeat (3) @(posedge mclk_i);
    #2;
    rst_n_i = 1'b1;
    chk("ctrl", 8'h05, ctrl_o);
    chk("dbg", 8'h00, dbg_o);
    chk("pair", 8'h00, pair_o);
    acc(1'b0, 1'b1, 3'h0, 8'h00);
    chk("rdata", 8'h05, rdata_o);
    $display("test reset done");
    foreach (rows[i]) begin
      acc(1'b1, 1'b0, rows[i].wa, rows[i].wd);
      acc(1'b0, 1'b1, rows[i].ra, 8'h00);
      chk("rdata", rows[i].ex, rdata_o);
    end
    chk("ctrl", 8'h3F, ctrl_o);
    chk("dbg", 8'h01, dbg_o);
    chk("pair", 8'h71, pair_o);
    $display("test rows done");
    status_i = 8'hF3;
    acc(1'b0, 1'b1, 3'h1, 8'h00);
    chk("rdata", 8'h03, rdata_o);
    acc(1'b1, 1'b0, 3'h5, 8'h80);
    acc(1'b1, 1'b1, 3'h6, 8'h01);
    chk("rdata", 8'hF1, rdata_o);
    acc(1'b0, 1'b1, 3'h4, 8'h00);
    chk("rdata", 8'hF0, rdata_o);
    chk("pair", 8'hF0, pair_o);
    $display("test back to back done");
    acc(1'b1, 1'b0, 3'h2, 8'h01);
    chk("ctrl", 8'h05, ctrl_o);
    chk("dbg", 8'h01, dbg_o);
    acc(1'b0, 1'b0, 3'h0, 8'h00);
    chk("pair", 8'h00, pair_o);
    acc(1'b1, 1'b0, 3'h2, 8'h02);
    chk("strobe", 8'h01, {7'h00, strobe_o});
    acc(1'b0, 1'b0, 3'h0, 8'h00);
    chk("strobe", 8'h00, {7'h00, strobe_o});
    $display("test command done");
    acc(1'b1, 1'b0, 3'h0, 8'h2A);
    acc(1'b1, 1'b0, 3'h7, 8'h0F);
    acc(1'b1, 1'b1, 3'h7, 8'h03);
    chk("rdata", 8'h0F, rdata_o);
    acc(1'b0, 1'b1, 3'h0, 8'h00);
    chk("rdata", 8'h2A, rdata_o);
    chk("pair", 8'h0C, pair_o);
    $display("test toggle twice done");
    rst_n_i = 1'b0;
    acc(1'b0, 1'b0, 3'h0, 8'h00);
    rst_n_i = 1'b1;
    chk("dbg", 8'h00, dbg_o);
    chk("ctrl", 8'h05, ctrl_o);
    chk("pair", 8'h00, pair_o);
    acc(1'b0, 1'b1, 3'h4, 8'h00);
    chk("rdata", 8'h00, rdata_o);
    $display("test hard reset done");
    stop_test();
  end
endmodule
